// [verilog/csa_scan_cfg.sv]
// scan and association configuration with channel scan sequencer
// assumes command-mode parameter port and radio status on core_clk;
// pin_wake comes from a pin and is synchronised here
`timescale 1ns/1ps
module csa_scan_cfg #(
    parameter bit     HIGH_POWER = 1'b0,
    parameter longint DWELL_CYC  = csa_pkg::DWELL_CYC_D,
    parameter longint GAP_CYC    = csa_pkg::GAP_CYC_D,
    parameter longint TAIL_CYC   = csa_pkg::TAIL_CYC_D
) (
    input  wire logic                        core_clk,
    input  wire logic                        nrst,
    input  wire logic                        wr_en,
    input  wire logic [csa_pkg::SEL_W-1:0]   wr_sel,
    input  wire logic [csa_pkg::DATA_W-1:0]  wr_data,
    output logic                             wr_err,
    input  wire logic [csa_pkg::SEL_W-1:0]   rd_sel,
    output logic [csa_pkg::DATA_W-1:0]       rd_data,
    input  wire logic                        scan_start,
    input  wire logic                        scan_energy,
    input  wire logic                        coord_start,
    output logic                             scan_busy,
    output logic                             scan_is_energy,
    output logic                             chan_listen,
    output logic [7:0]                       scan_chan,
    output logic                             scan_done,
    input  wire logic                        energy_valid,
    input  wire logic [7:0]                  energy_level,
    input  wire logic                        pan_conflict,
    output logic                             net_id_change,
    input  wire logic [7:0]                  configured_channel,
    output logic [7:0]                       op_channel,
    input  wire logic                        is_coord,
    input  wire logic                        beacon_net,
    input  wire logic                        associated,
    input  wire logic                        cand_valid,
    input  wire logic                        cand_pan_match,
    input  wire logic                        cand_chan_match,
    output logic                             assoc_try,
    output logic                             assoc_permit,
    input  wire logic                        pin_wake,
    output logic                             poll_req,
    input  wire logic                        assoc_req,
    output logic                             assoc_accept,
    output logic                             assoc_refuse
);
    import csa_pkg::*;

    // =========================================================
    // parameter registers
    logic [15:0] mask_ff;
    logic [3:0]  sdur_ff;
    logic [7:0]  edopt_ff;
    logic [7:0]  coopt_ff;
    logic        wr_err_ff;
    logic [15:0] rd_data_ff;

    wire w_mask  = wr_en && (wr_sel == SEL_MASK);
    wire w_sdur  = wr_en && (wr_sel == SEL_SDUR);
    wire w_edopt = wr_en && (wr_sel == SEL_EDOPT);
    wire w_coopt = wr_en && (wr_sel == SEL_COOPT);
    wire bad_sdur  = w_sdur && (wr_data > SDUR_MAX);
    wire bad_edopt = w_edopt && (wr_data > EDOPT_MAX);
    wire bad_coopt = w_coopt && (wr_data > COOPT_MAX);
    wire bad_sel   = wr_en && !(w_mask || w_sdur || w_edopt || w_coopt);
    wire bad_wr    = bad_sdur || bad_edopt || bad_coopt || bad_sel;

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            mask_ff   <= MASK_RST;
            sdur_ff   <= SDUR_RST;
            edopt_ff  <= EDOPT_RST;
            coopt_ff  <= COOPT_RST;
            wr_err_ff <= 1'b0;
        end
        else
        begin
            if (w_mask)
                mask_ff <= wr_data;
            if (w_sdur && !bad_sdur)
                sdur_ff <= wr_data[3:0];
            if (w_edopt && !bad_edopt)
                edopt_ff <= wr_data[7:0];
            if (w_coopt && !bad_coopt)
                coopt_ff <= wr_data[7:0];
            wr_err_ff <= bad_wr;
        end
    end
    assign wr_err = wr_err_ff;

    // =========================================================
    // effective channel mask, one bit per channel
    localparam logic [15:0] VAR_MASK = HIGH_POWER ? MASK_HP : MASK_STD;
    logic [15:0] eff_mask;
    for (genvar n = 0; n < 16; n++)
    begin : g_chan
        assign eff_mask[n] = mask_ff[n] && VAR_MASK[n];
    end

    function automatic logic [4:0] find_next(input logic [15:0] m,
                                             input logic [4:0]  from);
        logic [4:0] r;
        r = IDX_NONE;
        for (int i = 15; i >= 0; i--)
            if (m[i] && (i >= int'(from)))
                r = 5'(i);
        return r;
    endfunction : find_next

    // =========================================================
    // scan sequencer
    csa_state_type st_ff;
    csa_state_type nxt_st;
    logic [3:0]    idx_ff;
    logic          energy_ff;
    logic          from_coord_ff;
    logic          pend_active_ff;
    logic          conflict_ff;
    logic [7:0]    peak_ff;
    logic [7:0]    best_ff;
    logic [3:0]    best_idx_ff;
    logic [7:0]    scan_chan_ff;
    logic [7:0]    op_chan_ff;
    logic          scan_done_ff;
    logic          id_chg_ff;
    logic          tmr_load;
    logic [TMR_W-1:0] tmr_val;
    logic          tmr_done;

    wire [4:0] first_idx = find_next(eff_mask, 5'h00);
    wire [4:0] next_idx  = find_next(eff_mask, 5'(idx_ff) + 5'h01);
    wire idle       = (st_ff == ST_IDLE);
    wire cmd_go     = idle && scan_start;
    wire co_go      = idle && coord_start && !scan_start;
    wire co_energy  = coopt_ff[CO_CHAN];
    wire co_active  = coopt_ff[CO_PAN];
    wire co_scan    = co_go && (co_energy || co_active);
    wire go         = cmd_go || co_scan;
    wire go_energy  = cmd_go ? scan_energy : co_energy;
    wire tail_end   = (st_ff == ST_TAIL) && tmr_done;
    wire chain      = tail_end && from_coord_ff && pend_active_ff;
    wire start_any  = go || chain;
    wire gap_end    = (st_ff == ST_GAP) && tmr_done;
    wire dwell_end  = (st_ff == ST_DWELL) && tmr_done;
    wire [4:0] pick = start_any ? first_idx : next_idx;
    wire more       = !pick[4];

    wire [TMR_W-1:0] dwell_len = TMR_W'(DWELL_CYC) << sdur_ff;

    always_comb
    begin
        nxt_st   = st_ff;
        tmr_load = 1'b0;
        tmr_val  = TMR_W'(TAIL_CYC);
        case (st_ff)
            ST_IDLE:
                if (go)
                begin
                    tmr_load = 1'b1;
                    nxt_st   = more ? ST_DWELL : ST_TAIL;
                    tmr_val  = more ? dwell_len : TMR_W'(TAIL_CYC);
                end
            ST_DWELL:
                if (tmr_done)
                begin
                    tmr_load = 1'b1;
                    tmr_val  = TMR_W'(GAP_CYC);
                    nxt_st   = ST_GAP;
                end
            ST_GAP:
                if (tmr_done)
                begin
                    tmr_load = 1'b1;
                    nxt_st   = more ? ST_DWELL : ST_TAIL;
                    tmr_val  = more ? dwell_len : TMR_W'(TAIL_CYC);
                end
            ST_TAIL:
                if (tmr_done)
                begin
                    nxt_st = ST_IDLE;
                    if (chain)
                    begin
                        tmr_load = 1'b1;
                        nxt_st   = more ? ST_DWELL : ST_TAIL;
                        tmr_val  = more ? dwell_len : TMR_W'(TAIL_CYC);
                    end
                end
            default:
                nxt_st = ST_IDLE;
        endcase
    end

    csa_timer #(
        .W (TMR_W)
    ) u_timer (
        .core_clk (core_clk),
        .nrst     (nrst),
        .load     (tmr_load),
        .value    (tmr_val),
        .done     (tmr_done)
    );

    // quietest channel: largest -dBm of each channel's peak energy
    wire [7:0] peak_nxt = (energy_valid && (energy_level < peak_ff))
                          ? energy_level : peak_ff;
    wire better = dwell_end && energy_ff && (peak_nxt > best_ff);
    wire co_done = tail_end && from_coord_ff && !chain;

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            st_ff          <= ST_IDLE;
            idx_ff         <= 4'h0;
            energy_ff      <= 1'b0;
            from_coord_ff  <= 1'b0;
            pend_active_ff <= 1'b0;
            conflict_ff    <= 1'b0;
            peak_ff        <= LOUD_MAX;
            best_ff        <= QUIET_MIN;
            best_idx_ff    <= 4'h0;
            scan_chan_ff   <= CHAN_BASE;
            op_chan_ff     <= CHAN_BASE;
            scan_done_ff   <= 1'b0;
            id_chg_ff      <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            if ((start_any || gap_end) && more)
            begin
                idx_ff       <= pick[3:0];
                scan_chan_ff <= CHAN_BASE + 8'(pick[3:0]);
                peak_ff      <= LOUD_MAX;
            end
            else if (st_ff == ST_DWELL)
                peak_ff <= peak_nxt;
            if (go)
            begin
                energy_ff      <= go_energy;
                from_coord_ff  <= co_scan;
                pend_active_ff <= co_scan && co_energy && co_active;
                conflict_ff    <= 1'b0;
                best_ff        <= QUIET_MIN;
                best_idx_ff    <= 4'h0;
            end
            else if (chain)
            begin
                energy_ff      <= 1'b0;
                pend_active_ff <= 1'b0;
            end
            if (better)
            begin
                best_ff     <= peak_nxt;
                best_idx_ff <= idx_ff;
            end
            if ((st_ff == ST_DWELL) && !energy_ff && from_coord_ff
                && pan_conflict)
                conflict_ff <= 1'b1;
            if (co_go && !co_energy)
                op_chan_ff <= configured_channel;
            else if (tail_end && from_coord_ff && energy_ff)
                op_chan_ff <= CHAN_BASE + 8'(best_idx_ff);
            scan_done_ff <= tail_end && !chain;
            id_chg_ff    <= co_done && co_active
                            && (conflict_ff || (pan_conflict
                            && (st_ff == ST_DWELL)));
        end
    end

    assign scan_busy      = !idle;
    assign scan_is_energy = energy_ff;
    assign chan_listen    = (st_ff == ST_DWELL);
    assign scan_chan      = scan_chan_ff;
    assign scan_done      = scan_done_ff;
    assign net_id_change  = id_chg_ff;
    assign op_channel     = op_chan_ff;

    // =========================================================
    // association options
    assign assoc_permit = cand_valid && !is_coord
                          && (edopt_ff[ED_ANY_PAN] || cand_pan_match)
                          && (edopt_ff[ED_ANY_CHAN] || cand_chan_match);
    assign assoc_try    = !is_coord && !associated
                          && (beacon_net || edopt_ff[ED_AUTO]);
    assign assoc_accept = is_coord && assoc_req && coopt_ff[CO_ALLOW];
    assign assoc_refuse = is_coord && assoc_req && !coopt_ff[CO_ALLOW];

    // pin wake: two-flop synchroniser, edge taken from the second stage
    logic wake_s1_ff;
    logic wake_s2_ff;
    logic wake_s3_ff;
    logic poll_ff;
    wire  wake_rise = wake_s2_ff && !wake_s3_ff;

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            wake_s1_ff <= 1'b0;
            wake_s2_ff <= 1'b0;
            wake_s3_ff <= 1'b0;
            poll_ff    <= 1'b0;
        end
        else
        begin
            wake_s1_ff <= pin_wake;
            wake_s2_ff <= wake_s1_ff;
            wake_s3_ff <= wake_s2_ff;
            poll_ff    <= wake_rise && !is_coord && edopt_ff[ED_POLL];
        end
    end
    assign poll_req = poll_ff;

    // =========================================================
    // read-back
    wire [15:0] status_word = {8'h00, 1'b0, energy_ff, st_ff, idx_ff};
    wire [15:0] rd_mux =
        (rd_sel == SEL_MASK)   ? mask_ff :
        (rd_sel == SEL_SDUR)   ? {12'h000, sdur_ff} :
        (rd_sel == SEL_EDOPT)  ? {8'h00, edopt_ff} :
        (rd_sel == SEL_COOPT)  ? {8'h00, coopt_ff} :
        (rd_sel == SEL_STATUS) ? status_word : 16'h0000;

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            rd_data_ff <= 16'h0000;
        else
            rd_data_ff <= rd_mux;
    end
    assign rd_data = rd_data_ff;

    // =========================================================
    // assertions
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_wake_edge;
        !wake_s2_ff ##1 wake_s2_ff;
    endsequence
    sequence s_dwell_then_gap;
        (st_ff == ST_DWELL) && tmr_done ##1 (st_ff == ST_GAP);
    endsequence

    AST_CHAN_NUM: assert property (
        chan_listen |-> scan_chan == CHAN_BASE + 8'(idx_ff))
        else $error("channel number does not match mask bit");
    AST_MASK_GOV: assert property (
        chan_listen |-> eff_mask[idx_ff])
        else $error("listening on an unselected channel");
    AST_HP_BITS: assert property (
        chan_listen && HIGH_POWER |-> (idx_ff != 4'h0) && (idx_ff < 4'hd))
        else $error("unavailable channel scanned on high-power part");
    AST_RST_VAL: assert property (
        $rose(nrst) |-> mask_ff == MASK_RST && sdur_ff == SDUR_RST)
        else $error("reset values wrong");
    AST_DWELL_LEN: assert property (
        tmr_load && (nxt_st == ST_DWELL) |-> tmr_val == dwell_len)
        else $error("dwell length not derived from exponent");
    AST_GAP_LEN: assert property (
        s_dwell_then_gap |-> $past(tmr_val) == TMR_W'(GAP_CYC))
        else $error("gap after channel is not 38 ms");
    AST_REJECT: assert property (
        bad_wr |=> wr_err && $stable(sdur_ff) && $stable(edopt_ff)
                   && $stable(coopt_ff))
        else $error("out-of-range write changed a setting");
    AST_PAN_MATCH: assert property (
        assoc_permit && !edopt_ff[ED_ANY_PAN] |-> cand_pan_match)
        else $error("association permitted on foreign network");
    AST_BEACON_JOIN: assert property (
        beacon_net && !is_coord && !associated |-> assoc_try)
        else $error("beacon end device not associating");
    AST_POLL: assert property (
        s_wake_edge ##0 (edopt_ff[ED_POLL] && !is_coord) |=> poll_req)
        else $error("pin wake did not poll");
    AST_ACCEPT: assert property (
        is_coord && assoc_req |-> assoc_accept == coopt_ff[CO_ALLOW])
        else $error("association acceptance ignores option");

endmodule : csa_scan_cfg

// [verilog/csa_pkg.sv]
// constants and types for the channel scan and association config block
// assumes one 100 MHz core clock and a synchronous active-low reset
package csa_pkg;

    // =========================================================
    // parameter select codes
    localparam int SEL_W = 3;
    typedef enum logic [SEL_W-1:0] {
        SEL_MASK   = 3'b000,
        SEL_SDUR   = 3'b001,
        SEL_EDOPT  = 3'b010,
        SEL_COOPT  = 3'b011,
        SEL_STATUS = 3'b100
    } csa_sel_type;

    // =========================================================
    // widths, ranges, reset values
    localparam int DATA_W = 16;
    localparam logic [15:0] MASK_RST   = 16'h1ffe;
    localparam logic [15:0] MASK_HP    = 16'h1ffe;
    localparam logic [15:0] MASK_STD   = 16'hffff;
    localparam logic [3:0]  SDUR_RST   = 4'h4;
    localparam logic [15:0] SDUR_MAX   = 16'h000f;
    localparam logic [7:0]  EDOPT_RST  = 8'h00;
    localparam logic [15:0] EDOPT_MAX  = 16'h000f;
    localparam logic [7:0]  COOPT_RST  = 8'h00;
    localparam logic [15:0] COOPT_MAX  = 16'h0007;
    localparam logic [7:0]  CHAN_BASE  = 8'h0b;
    localparam logic [4:0]  IDX_NONE   = 5'h10;
    localparam logic [7:0]  QUIET_MIN  = 8'h00;
    localparam logic [7:0]  LOUD_MAX   = 8'hff;

    // =========================================================
    // option bit positions
    localparam int ED_ANY_PAN  = 0;
    localparam int ED_ANY_CHAN = 1;
    localparam int ED_AUTO     = 2;
    localparam int ED_POLL     = 3;
    localparam int CO_PAN      = 0;
    localparam int CO_CHAN     = 1;
    localparam int CO_ALLOW    = 2;

    // =========================================================
    // timing
    localparam longint CLK_PERIOD_NS = 10;
    localparam longint DWELL_BASE_NS = 15_360_000;
    localparam longint GAP_NS        = 38_000_000;
    localparam longint TAIL_NS       = 20_000_000;
    localparam longint DWELL_CYC_D   = DWELL_BASE_NS / CLK_PERIOD_NS;
    localparam longint GAP_CYC_D     = GAP_NS / CLK_PERIOD_NS;
    localparam longint TAIL_CYC_D    = TAIL_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 40;

    // =========================================================
    // scan sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DWELL = 2'b01,
        ST_GAP   = 2'b10,
        ST_TAIL  = 2'b11
    } csa_state_type;

endpackage : csa_pkg

// [verilog/csa_timer.sv]
// one-shot down counter for scan dwell, gap and tail periods
// assumes load and value come from logic on core_clk
`timescale 1ns/1ps
module csa_timer #(
    parameter int W = 40
) (
    input  wire logic         core_clk,
    input  wire logic         nrst,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic              done
);
    import csa_pkg::*;

    // =========================================================
    // counter
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic         run_ff;
    logic         nxt_run;
    wire          last = run_ff && (cnt_ff == W'(1));

    assign nxt_cnt = load ? value : (run_ff ? cnt_ff - W'(1) : cnt_ff);
    assign nxt_run = load ? (value != '0) : (run_ff && !last);
    assign done    = last;

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            run_ff <= nxt_run;
        end
    end

endmodule : csa_timer

// [test/csa_scan_cfg_tb_top.sv]
// self-checking bench for the scan and association config block
// assumes shortened dwell, gap and tail counts; inputs move at negedge
`timescale 1ns/1ps
module csa_scan_cfg_tb_top;
    import csa_pkg::*;
    localparam longint DW = 4;
    localparam longint GP = 3;
    localparam longint TL = 2;
    logic core_clk, nrst, wr_en, scan_start, scan_energy, coord_start;
    logic energy_valid, pan_conflict, is_coord, beacon_net, associated;
    logic cand_valid, cand_pan_match, cand_chan_match, pin_wake, assoc_req;
    logic [SEL_W-1:0]  wr_sel, rd_sel;
    logic [DATA_W-1:0] wr_data, rd_data;
    logic [7:0] energy_level, configured_channel, scan_chan, op_channel;
    logic wr_err, scan_busy, scan_is_energy, chan_listen, scan_done;
    logic net_id_change, assoc_try, assoc_permit, poll_req;
    logic assoc_accept, assoc_refuse;
    logic hp_listen;
    int   n_errors, checked;
    csa_scan_cfg #(.DWELL_CYC(DW), .GAP_CYC(GP), .TAIL_CYC(TL)) DUT (
        .core_clk(core_clk), .nrst(nrst), .wr_en(wr_en), .wr_sel(wr_sel),
        .wr_data(wr_data), .wr_err(wr_err), .rd_sel(rd_sel),
        .rd_data(rd_data), .scan_start(scan_start),
        .scan_energy(scan_energy), .coord_start(coord_start),
        .scan_busy(scan_busy), .scan_is_energy(scan_is_energy),
        .chan_listen(chan_listen), .scan_chan(scan_chan),
        .scan_done(scan_done), .energy_valid(energy_valid),
        .energy_level(energy_level), .pan_conflict(pan_conflict),
        .net_id_change(net_id_change),
        .configured_channel(configured_channel), .op_channel(op_channel),
        .is_coord(is_coord), .beacon_net(beacon_net),
        .associated(associated), .cand_valid(cand_valid),
        .cand_pan_match(cand_pan_match), .cand_chan_match(cand_chan_match),
        .assoc_try(assoc_try), .assoc_permit(assoc_permit),
        .pin_wake(pin_wake), .poll_req(poll_req), .assoc_req(assoc_req),
        .assoc_accept(assoc_accept), .assoc_refuse(assoc_refuse));
    // high-power variant, fed the same stimulus
    csa_scan_cfg #(.HIGH_POWER(1'b1), .DWELL_CYC(DW), .GAP_CYC(GP),
        .TAIL_CYC(TL)) DUT_HP (
        .core_clk(core_clk), .nrst(nrst), .wr_en(wr_en), .wr_sel(wr_sel),
        .wr_data(wr_data), .wr_err(), .rd_sel(rd_sel), .rd_data(),
        .scan_start(scan_start), .scan_energy(scan_energy),
        .coord_start(coord_start), .scan_busy(), .scan_is_energy(),
        .chan_listen(hp_listen), .scan_chan(), .scan_done(),
        .energy_valid(energy_valid), .energy_level(energy_level),
        .pan_conflict(pan_conflict), .net_id_change(),
        .configured_channel(configured_channel), .op_channel(),
        .is_coord(is_coord), .beacon_net(beacon_net),
        .associated(associated), .cand_valid(cand_valid),
        .cand_pan_match(cand_pan_match), .cand_chan_match(cand_chan_match),
        .assoc_try(), .assoc_permit(), .pin_wake(pin_wake), .poll_req(),
        .assoc_req(assoc_req), .assoc_accept(), .assoc_refuse());
    // =========================================================
    // clock and shared tasks
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] s, input logic [15:0] d,
                      input logic e);
        logic seen;
        @(negedge core_clk);
        wr_en = 1'b1;
        wr_sel = s;
        wr_data = d;
        @(negedge core_clk);
        wr_en = 1'b0;
        seen = wr_err;
        @(negedge core_clk);
        seen = seen | wr_err;
        chk({15'h0, seen}, {15'h0, e});
    endtask : wr
    task automatic rd(input logic [2:0] s, input logic [15:0] e);
        @(negedge core_clk);
        rd_sel = s;
        @(negedge core_clk);
        chk(rd_data, e);
    endtask : rd
    task automatic wrap_up;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    // =========================================================
    // scenarios
    task automatic t_regs;
        rd(SEL_MASK, 16'h1ffe);
        rd(SEL_SDUR, 16'h0004);
        rd(SEL_EDOPT, 16'h0000);
        wr(SEL_SDUR, 16'h0010, 1'b1);
        rd(SEL_SDUR, 16'h0004);
        wr(SEL_EDOPT, 16'h0010, 1'b1);
        wr(SEL_COOPT, 16'h0008, 1'b1);
        rd(SEL_COOPT, 16'h0000);
        wr(SEL_MASK, 16'hffff, 1'b0);
        rd(SEL_MASK, 16'hffff);
        wr(SEL_SDUR, 16'h000f, 1'b0);
        rd(SEL_SDUR, 16'h000f);
    endtask : t_regs
    task automatic t_scan(input logic coord, input logic en);
        int busy, lis, k, hp;
        logic [7:0] ch[2];
        logic last;
        busy = 0;
        lis = 0;
        k = 0;
        hp = 0;
        last = 1'b0;
        wr(SEL_MASK, 16'h8001, 1'b0);
        wr(SEL_SDUR, 16'h0001, 1'b0);
        wr(SEL_COOPT, {14'h0, en, ~en}, 1'b0);
        @(negedge core_clk);
        scan_energy = en;
        scan_start = ~coord;
        coord_start = coord;
        @(negedge core_clk);
        scan_start = 1'b0;
        coord_start = 1'b0;
        for (int i = 0; i < 100 && scan_busy === 1'b1; i++)
        begin
            busy++;
            if (hp_listen !== 1'b0)
                hp++;
            if (chan_listen === 1'b1)
            begin
                lis++;
                chk({15'h0, scan_is_energy}, {15'h0, en});
                if (last === 1'b0 && k < 2)
                begin
                    ch[k] = scan_chan;
                    k++;
                end
            end
            last = chan_listen;
            @(negedge core_clk);
        end
        chk(16'(busy), 16'(2 * ((DW << 1) + GP) + TL));
        chk(16'(lis), 16'(2 * (DW << 1)));
        chk({8'h0, ch[0]}, 16'h000b);
        chk({8'h0, ch[1]}, 16'h001a);
        chk({15'h0, scan_done}, 16'h0001);
        chk(16'(hp), 16'h0000);
        chk({15'h0, net_id_change}, 16'h0000);
        if (coord)
            chk({8'h0, op_channel}, {8'h0, configured_channel});
    endtask : t_scan
    task automatic t_coord_scan;
        int busy;
        busy = 0;
        wr(SEL_MASK, 16'h0006, 1'b0);
        wr(SEL_COOPT, 16'h0003, 1'b0);
        @(negedge core_clk);
        coord_start = 1'b1;
        @(negedge core_clk);
        coord_start = 1'b0;
        for (int i = 0; i < 100 && scan_busy === 1'b1; i++)
        begin
            busy++;
            energy_valid = chan_listen & scan_is_energy;
            pan_conflict = chan_listen & ~scan_is_energy;
            energy_level = (scan_chan == 8'h0d) ? 8'h50 : 8'h20;
            @(negedge core_clk);
        end
        {energy_valid, pan_conflict} = '0;
        chk(16'(busy), 16'(4 * ((DW << 1) + GP) + 2 * TL));
        chk({8'h0, op_channel}, 16'h000d);
        chk({15'h0, net_id_change}, 16'h0001);
        chk({15'h0, scan_done}, 16'h0001);
    endtask : t_coord_scan
    task automatic t_assoc;
        cand_valid = 1'b1;
        for (int v = 0; v < 16; v++)
        begin
            wr(SEL_EDOPT, 16'(v[2:0]), 1'b0);
            cand_pan_match = v[3];
            cand_chan_match = v[2];
            beacon_net = v[3];
            @(negedge core_clk);
            chk({15'h0, assoc_permit},
                {15'h0, (v[0] | v[3]) & (v[1] | v[2])});
            chk({15'h0, assoc_try}, {15'h0, v[2] | v[3]});
        end
    endtask : t_assoc
    task automatic t_coord_poll;
        logic got;
        got = 1'b0;
        is_coord = 1'b1;
        assoc_req = 1'b1;
        wr(SEL_COOPT, 16'h0004, 1'b0);
        chk({15'h0, assoc_accept}, 16'h0001);
        wr(SEL_COOPT, 16'h0000, 1'b0);
        chk({15'h0, assoc_refuse}, 16'h0001);
        is_coord = 1'b0;
        assoc_req = 1'b0;
        wr(SEL_EDOPT, 16'h0008, 1'b0);
        pin_wake = 1'b1;
        repeat (8)
        begin
            @(negedge core_clk);
            got = got | poll_req;
        end
        pin_wake = 1'b0;
        chk({15'h0, got}, 16'h0001);
    endtask : t_coord_poll
    // =========================================================
    // main sequence and watchdog
    initial
    begin
        n_errors = 0;
        checked = 0;
        {nrst, wr_en, scan_start, scan_energy, coord_start} = '0;
        {energy_valid, pan_conflict, is_coord, beacon_net} = '0;
        {associated, cand_valid, cand_pan_match, cand_chan_match} = '0;
        {pin_wake, assoc_req} = '0;
        wr_sel = '0;
        rd_sel = '0;
        wr_data = '0;
        energy_level = 8'h40;
        configured_channel = 8'h0c;
        repeat (10) @(negedge core_clk);
        nrst = 1'b1;
        t_regs();
        t_scan(1'b0, 1'b0);
        t_scan(1'b0, 1'b1);
        t_scan(1'b1, 1'b0);
        t_coord_scan();
        t_assoc();
        t_coord_poll();
        wrap_up();
    end
    initial
    begin
        #200000;
        n_errors++;
        wrap_up();
    end
endmodule : csa_scan_cfg_tb_top
